// ==== core/sipc_irq_pins.sv ====
// module: interrupt source enable, routing and pin drive
`timescale 1ns/1ps
`default_nettype none
module sipc_irq_pins
  import sipc_pkg::*;
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  // register port from the serial interface logic
  input  wire sipc_req_s          req,
  output logic [SIPC_DW-1:0]      rdata,
  // event flags from the functional blocks, same clock
  input  wire logic [SIPC_DW-1:0] event_flags,
  // interrupt pads
  output logic                    first_irq_pin_out,
  output logic                    first_irq_pin_oe_b,
  output logic                    second_irq_pin_out,
  output logic                    second_irq_pin_oe_b
);
  sipc_state_s st_reg;
  sipc_state_s st_next;
  logic [SIPC_DW-1:0] gated;
  logic               first_any;
  logic               second_any;

  function automatic sipc_pin_s drive(input logic active, input logic pol, input logic od);
    sipc_pin_s p;
    p.out  = active ? pol : ~pol;
    // open drain can only pull low; high level comes from the pullup outside
    p.oe_b = od ? (p.out == 1'b1) : 1'b0;
    return p;
  endfunction

  always_comb begin
    st_next    = st_reg;
    gated      = event_flags & st_reg.source_enable_reg;
    first_any  = |(gated & st_reg.pin_routing_reg);
    second_any = |(gated & ~st_reg.pin_routing_reg);
    if (req.wr_en) begin
      case (req.addr)
        SIPC_OFS_PIN_CONFIG:    st_next.pin_config_reg    = req.wdata & SIPC_PIN_CONFIG_MASK;
        SIPC_OFS_SOURCE_ENABLE: st_next.source_enable_reg = req.wdata;
        SIPC_OFS_PIN_ROUTING:   st_next.pin_routing_reg   = req.wdata;
        default: begin
        end
      endcase
    end
    if (req.rd_en) begin
      case (req.addr)
        SIPC_OFS_PIN_CONFIG:    st_next.rdata_reg = st_reg.pin_config_reg;
        SIPC_OFS_SOURCE_ENABLE: st_next.rdata_reg = st_reg.source_enable_reg;
        SIPC_OFS_PIN_ROUTING:   st_next.rdata_reg = st_reg.pin_routing_reg;
        default:                st_next.rdata_reg = SIPC_RST_VALUE;
      endcase
    end
    st_next.first_active_reg  = first_any;
    st_next.second_active_reg = second_any;
    st_next.first_pin_reg  = drive(first_any, st_reg.pin_config_reg[SIPC_BIT_FIRST_POL],
                                   st_reg.pin_config_reg[SIPC_BIT_FIRST_DRIVE]);
    st_next.second_pin_reg = drive(second_any, st_reg.pin_config_reg[SIPC_BIT_SECOND_POL],
                                   st_reg.pin_config_reg[SIPC_BIT_SECOND_DRIVE]);
  end

  // reset: pins idle active-low push-pull, driven high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{pin_config_reg: SIPC_RST_VALUE, source_enable_reg: SIPC_RST_VALUE,
                  pin_routing_reg: SIPC_RST_VALUE, rdata_reg: SIPC_RST_VALUE,
                  first_active_reg: 1'b0, second_active_reg: 1'b0,
                  first_pin_reg: '{out: 1'b1, oe_b: 1'b0},
                  second_pin_reg: '{out: 1'b1, oe_b: 1'b0}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata               = st_reg.rdata_reg;
  assign first_irq_pin_out   = st_reg.first_pin_reg.out;
  assign first_irq_pin_oe_b  = st_reg.first_pin_reg.oe_b;
  assign second_irq_pin_out  = st_reg.second_pin_reg.out;
  assign second_irq_pin_oe_b = st_reg.second_pin_reg.oe_b;

  property p_reserved_zero;
    @(posedge core_clk) disable iff (!rst_b)
      (st_reg.pin_config_reg & ~SIPC_PIN_CONFIG_MASK) == SIPC_RST_VALUE;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved config bits set");

  property p_disabled_quiet;
    @(posedge core_clk) disable iff (!rst_b)
      (st_reg.source_enable_reg == SIPC_RST_VALUE) && $stable(st_reg.source_enable_reg)
        |=> !st_reg.first_active_reg && !st_reg.second_active_reg;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled source reached pin");

  property p_one_pin;
    @(posedge core_clk) disable iff (!rst_b)
      ($onehot(gated) && $stable(st_reg.pin_routing_reg))
        |=> (st_reg.first_active_reg ^ st_reg.second_active_reg);
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("source on both or no pin");

  property p_route_first;
    @(posedge core_clk) disable iff (!rst_b)
      |(gated & st_reg.pin_routing_reg) |=> st_reg.first_active_reg;
  endproperty
  a_route_first: assert property (p_route_first) else $error("routed source missed first pin");

  property p_first_level;
    @(posedge core_clk) disable iff (!rst_b)
      first_any |=> (first_irq_pin_out == $past(st_reg.pin_config_reg[SIPC_BIT_FIRST_POL]));
  endproperty
  a_first_level: assert property (p_first_level) else $error("first pin wrong active level");

  property p_second_idle;
    @(posedge core_clk) disable iff (!rst_b)
      !second_any |=> (second_irq_pin_out != st_reg.pin_config_reg[SIPC_BIT_SECOND_POL])
                      || $changed(st_reg.pin_config_reg);
  endproperty
  a_second_idle: assert property (p_second_idle) else $error("second pin not idle");

  property p_od_release;
    @(posedge core_clk) disable iff (!rst_b)
      // the pad follows the mode stored one edge earlier
      $past(st_reg.pin_config_reg[SIPC_BIT_FIRST_DRIVE]) && first_irq_pin_out |-> first_irq_pin_oe_b;
  endproperty
  a_od_release: assert property (p_od_release) else $error("open drain drove high");

  property p_pp_drive;
    @(posedge core_clk) disable iff (!rst_b)
      !st_reg.pin_config_reg[SIPC_BIT_SECOND_DRIVE] ##1 !$past(st_reg.pin_config_reg[SIPC_BIT_SECOND_DRIVE])
        |-> !second_irq_pin_oe_b;
  endproperty
  a_pp_drive: assert property (p_pp_drive) else $error("push-pull pin released");

  property p_enable_write;
    @(posedge core_clk) disable iff (!rst_b)
      req.wr_en && req.addr == SIPC_OFS_SOURCE_ENABLE |=> st_reg.source_enable_reg == $past(req.wdata);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_first_idle;
    @(posedge core_clk) disable iff (!rst_b)
      !first_any |=> (first_irq_pin_out != $past(st_reg.pin_config_reg[SIPC_BIT_FIRST_POL]));
  endproperty
  a_first_idle: assert property (p_first_idle) else $error("first pin not idle");

  property p_second_level;
    @(posedge core_clk) disable iff (!rst_b)
      second_any |=> (second_irq_pin_out == $past(st_reg.pin_config_reg[SIPC_BIT_SECOND_POL]));
  endproperty
  a_second_level: assert property (p_second_level) else $error("second pin wrong active level");

  property p_od_release_second;
    @(posedge core_clk) disable iff (!rst_b)
      $past(st_reg.pin_config_reg[SIPC_BIT_SECOND_DRIVE]) && second_irq_pin_out |-> second_irq_pin_oe_b;
  endproperty
  a_od_release_second: assert property (p_od_release_second) else $error("second open drain drove high");

  property p_pp_drive_first;
    @(posedge core_clk) disable iff (!rst_b)
      !$past(st_reg.pin_config_reg[SIPC_BIT_FIRST_DRIVE]) |-> !first_irq_pin_oe_b;
  endproperty
  a_pp_drive_first: assert property (p_pp_drive_first) else $error("first push-pull pin released");

  property p_od_drive_low;
    @(posedge core_clk) disable iff (!rst_b)
      $past(st_reg.pin_config_reg[SIPC_BIT_SECOND_DRIVE]) && !second_irq_pin_out |-> !second_irq_pin_oe_b;
  endproperty
  a_od_drive_low: assert property (p_od_drive_low) else $error("open drain failed to pull low");

  property p_route_second;
    @(posedge core_clk) disable iff (!rst_b)
      |(gated & ~st_reg.pin_routing_reg) |=> st_reg.second_active_reg;
  endproperty
  a_route_second: assert property (p_route_second) else $error("routed source missed second pin");

  property p_first_quiet;
    @(posedge core_clk) disable iff (!rst_b)
      !(|(gated & st_reg.pin_routing_reg)) |=> !st_reg.first_active_reg;
  endproperty
  a_first_quiet: assert property (p_first_quiet) else $error("first pin raised without source");

  property p_second_quiet;
    @(posedge core_clk) disable iff (!rst_b)
      !(|(gated & ~st_reg.pin_routing_reg)) |=> !st_reg.second_active_reg;
  endproperty
  a_second_quiet: assert property (p_second_quiet) else $error("second pin raised without source");

  property p_config_write;
    @(posedge core_clk) disable iff (!rst_b)
      req.wr_en && req.addr == SIPC_OFS_PIN_CONFIG
        |=> st_reg.pin_config_reg == ($past(req.wdata) & SIPC_PIN_CONFIG_MASK);
  endproperty
  a_config_write: assert property (p_config_write) else $error("config write lost");

  property p_routing_write;
    @(posedge core_clk) disable iff (!rst_b)
      req.wr_en && req.addr == SIPC_OFS_PIN_ROUTING |=> st_reg.pin_routing_reg == $past(req.wdata);
  endproperty
  a_routing_write: assert property (p_routing_write) else $error("routing write lost");

  property p_enable_hold;
    @(posedge core_clk) disable iff (!rst_b)
      !(req.wr_en && req.addr == SIPC_OFS_SOURCE_ENABLE) |=> $stable(st_reg.source_enable_reg);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable changed without write");

  property p_read_enable;
    @(posedge core_clk) disable iff (!rst_b)
      req.rd_en && req.addr == SIPC_OFS_SOURCE_ENABLE |=> rdata == $past(st_reg.source_enable_reg);
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("enable readback wrong");

  property p_reserved_read;
    @(posedge core_clk) disable iff (!rst_b)
      req.rd_en && req.addr == SIPC_OFS_PIN_CONFIG |=> (rdata & ~SIPC_PIN_CONFIG_MASK) == SIPC_RST_VALUE;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits read nonzero");

  property p_gate_closed;
    @(posedge core_clk) disable iff (!rst_b)
      (gated == SIPC_RST_VALUE) |=> !st_reg.first_active_reg && !st_reg.second_active_reg;
  endproperty
  a_gate_closed: assert property (p_gate_closed) else $error("gated event reached pin");
endmodule
`default_nettype wire

// ==== core/sipc_pkg.sv ====
// package: register map, field positions and carrier types of the interrupt pin block
package sipc_pkg;
  localparam int unsigned SIPC_AW = 8;
  localparam int unsigned SIPC_DW = 8;
  localparam logic [SIPC_AW-1:0] SIPC_OFS_PIN_CONFIG    = 8'h28;
  localparam logic [SIPC_AW-1:0] SIPC_OFS_SOURCE_ENABLE = 8'h29;
  localparam logic [SIPC_AW-1:0] SIPC_OFS_PIN_ROUTING   = 8'h2A;
  localparam logic [SIPC_DW-1:0] SIPC_RST_VALUE         = 8'h00;
  localparam logic [SIPC_DW-1:0] SIPC_PIN_CONFIG_MASK   = 8'h33;
  localparam int unsigned SIPC_BIT_FIRST_POL   = 5;
  localparam int unsigned SIPC_BIT_FIRST_DRIVE = 4;
  localparam int unsigned SIPC_BIT_SECOND_POL  = 1;
  localparam int unsigned SIPC_BIT_SECOND_DRIVE = 0;
  // source enable and routing share one bit order
  localparam int unsigned SIPC_SRC_DATA_READY  = 7;
  localparam int unsigned SIPC_SRC_FIFO        = 6;
  localparam int unsigned SIPC_SRC_PRESS_WIN   = 5;
  localparam int unsigned SIPC_SRC_TEMP_WIN    = 4;
  localparam int unsigned SIPC_SRC_PRESS_TH    = 3;
  localparam int unsigned SIPC_SRC_TEMP_TH     = 2;
  localparam int unsigned SIPC_SRC_PRESS_CHG   = 1;
  localparam int unsigned SIPC_SRC_TEMP_CHG    = 0;

  typedef struct packed {
    logic                 wr_en;
    logic                 rd_en;
    logic [SIPC_AW-1:0]   addr;
    logic [SIPC_DW-1:0]   wdata;
  } sipc_req_s;

  typedef struct packed {
    logic                 out;
    logic                 oe_b;
  } sipc_pin_s;

  typedef struct packed {
    logic [SIPC_DW-1:0]   pin_config_reg;
    logic [SIPC_DW-1:0]   source_enable_reg;
    logic [SIPC_DW-1:0]   pin_routing_reg;
    logic [SIPC_DW-1:0]   rdata_reg;
    logic                 first_active_reg;
    logic                 second_active_reg;
    sipc_pin_s            first_pin_reg;
    sipc_pin_s            second_pin_reg;
  } sipc_state_s;
endpackage

// ==== sim/sipc_host_model.sv ====
// host side model: resolves both interrupt lines through their pullups
`timescale 1ns/1ps
`default_nettype none
module sipc_host_model (
  // pad drive from the device
  input  wire logic first_out,
  input  wire logic first_oe_b,
  input  wire logic second_out,
  input  wire logic second_oe_b,
  // line levels the host sees
  output logic      first_line,
  output logic      second_line
);
  // a released line rises to the pullup, never keeps a stale value
  assign first_line  = first_oe_b ? 1'b1 : first_out;
  assign second_line = second_oe_b ? 1'b1 : second_out;
endmodule
`default_nettype wire

// ==== sim/test_sensor_irq_pin_config_enable.sv ====
// testbench: register access, source enable, routing and pin drive
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_sensor_irq_pin_config_enable;
  import sipc_pkg::*;
  logic               core_clk = 1'b0;
  logic               rst_b    = 1'b0;
  sipc_req_s          req      = '0;
  logic [SIPC_DW-1:0] ev       = 8'h00;
  logic [SIPC_DW-1:0] rdata;
  logic               p1o, p1e, p2o, p2e, l1, l2;
  int                 err_total = 0, cmp_count = 0, cyc = 0;
  always #12.5 core_clk = ~core_clk;
  sipc_irq_pins u_dut (.core_clk(core_clk), .rst_b(rst_b), .req(req), .rdata(rdata), .event_flags(ev),
    .first_irq_pin_out(p1o), .first_irq_pin_oe_b(p1e), .second_irq_pin_out(p2o), .second_irq_pin_oe_b(p2e));
  sipc_host_model u_host (.first_out(p1o), .first_oe_b(p1e), .second_out(p2o), .second_oe_b(p2e),
    .first_line(l1), .second_line(l2));
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    req.wr_en = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk);
    req.rd_en = 1'b0;
    `CHK(rdata, e)
  endtask
  // two edges: the first registers the pins, the second only adds margin
  task automatic pins(input logic [1:0] e);
    repeat (2) @(negedge core_clk);
    `CHK({l1, l2}, e)
  endtask
  // a hang costs a mismatch, then the normal closing report
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    rdc(SIPC_OFS_PIN_CONFIG, 8'h00);
    rdc(SIPC_OFS_SOURCE_ENABLE, 8'h00);
    rdc(SIPC_OFS_PIN_ROUTING, 8'h00);
    pins(2'b11);
    wr(SIPC_OFS_PIN_CONFIG, 8'hFF);
    rdc(SIPC_OFS_PIN_CONFIG, 8'h33);
    rdc(8'h30, 8'h00);
    wr(SIPC_OFS_PIN_CONFIG, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ev = 8'h01 << i;
      wr(SIPC_OFS_SOURCE_ENABLE, 8'h00);
      pins(2'b11);
      wr(SIPC_OFS_SOURCE_ENABLE, ev);
      rdc(SIPC_OFS_SOURCE_ENABLE, ev);
      wr(SIPC_OFS_PIN_ROUTING, ev);
      pins(2'b01);
      wr(SIPC_OFS_PIN_ROUTING, ~ev);
      pins(2'b10);
    end
    wr(SIPC_OFS_SOURCE_ENABLE, 8'hFF);
    wr(SIPC_OFS_PIN_ROUTING, 8'h0F);
    ev = 8'h81;
    pins(2'b00);
    wr(SIPC_OFS_PIN_ROUTING, 8'h81);
    pins(2'b01);
    ev = 8'h01;
    pins(2'b01);
    ev = 8'h81;
    wr(SIPC_OFS_PIN_ROUTING, 8'h0F);
    wr(SIPC_OFS_PIN_CONFIG, 8'h22);
    pins(2'b11);
    ev = 8'h00;
    pins(2'b00);
    wr(SIPC_OFS_PIN_CONFIG, 8'h11);
    // pads pick up the new mode one edge after the store
    @(negedge core_clk);
    `CHK({p1e, p2e}, 2'b11)
    ev = 8'h81;
    pins(2'b00);
    wr(SIPC_OFS_PIN_CONFIG, 8'h33);
    repeat (2) @(negedge core_clk);
    `CHK({p1e, p2e}, 2'b11)
    `CHK({l1, l2}, 2'b11)
    // mid-run reset: everything back to idle with events still present
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(rdata, 8'h00)
    rst_b = 1'b1;
    rdc(SIPC_OFS_PIN_CONFIG, 8'h00);
    rdc(SIPC_OFS_SOURCE_ENABLE, 8'h00);
    rdc(SIPC_OFS_PIN_ROUTING, 8'h00);
    `CHK({p1e, p2e}, 2'b00)
    `CHK({l1, l2}, 2'b11)
    end_of_test();
  end
endmodule
`default_nettype wire
